// file: design/ftw_defs.vh
// constants for the fiber trigger word link block
// assumes inclusion by bare name from every design file that needs it
// Functional notes
// - one 16-bit word per 16 ns frame
// - bits 13:12 give the word type
// - time word compared with local time
// - strobe word drives prompt trigger outputs
// - quadrant field picks 4 ns slot
// - content pairs with oldest unmatched strobe
// - status word carries five sync_ack bits 7:3
// - type 10 words select payload by code
// - pair one trigger/status, two clock, three sync
// - standard mode measures fiber loop delay
// - master mode loops back delay ports
// - one clock from four sources
// - board switch default, software override
// - four backplane clock frequency selects
// - synchronized 41.67 MHz legacy clock enable
// - master forwards front-panel trigger, encoded
// - two fiber groups, optionally identical
// - generated stream decoded like fiber input
// - master mode from oscillator or cable source
`ifndef FTW_DEFS_VH
`define FTW_DEFS_VH
// =============================================
// word format
`define FTW_TYPE_HI 13
`define FTW_TYPE_LO 12
`define FTW_TYPE_TIME 2'h0
`define FTW_TYPE_CTRL 2'h1
`define FTW_TYPE_STROBE 2'h2
`define FTW_TYPE_CONTENT 2'h3
`define FTW_QUAD_LAST 2'h3
`define FTW_CODE_CRATE 3'h1
`define FTW_CODE_SOURCE 3'h2
`define FTW_CODE_LEVEL 3'h3
// =============================================
// clock sources
`define FTW_SRC_OSC 2'h0
`define FTW_SRC_CABLE 2'h1
// =============================================
// register offsets
`define FTW_REG_CTRL 12'h000
`define FTW_REG_CLKCFG 12'h004
`define FTW_REG_STATUS 12'h008
`define FTW_REG_DELAY 12'h00c
`define FTW_REG_REPORT 12'h010
`define FTW_REG_PAIR 12'h014
// ctrl bits
`define FTW_CTRL_CLR_SYNC 0
`define FTW_CTRL_MEASURE 1
`define FTW_CTRL_OVERRIDE 2
`define FTW_CTRL_SAME_GRP 3
`define FTW_CTRL_SD_PULSE 4
`define FTW_CTRL_REPORT_GO 5
`define FTW_CTRL_CLK41 6
`define FTW_CTRL_CLR_ORPHAN 7
// =============================================
// timing
`define FTW_DELAY_PULSE 3'h4
`define FTW_DELAY_MAX 16'hffff
`endif

// file: design/ftw_pair_mem.v
// small queue memory holding strobe words that wait for content
// assumes one clock; read data registered, valid one edge after address
module ftw_pair_mem #(
  parameter WIDTH = 12,
  parameter AW = 3
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [WIDTH-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [WIDTH-1:0] rdata
);
  // storage, no reset: contents only read after a write
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];

  // =============================================
  // write and registered read
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // ftw_pair_mem

// file: design/ftw_top.v
// fiber trigger word decoder, status encoder, delay meter and master generator
// assumes rx_word comes from the fixed-latency fifo on clk, and an apb master on clk
//
// Local design decisions: the register addresses and the APB register port.
`include "ftw_defs.vh"
module ftw_top #(
  parameter QAW = 3
) (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] rx_word,
  input wire rx_valid,
  input wire [4:0] fe_status,
  input wire [7:0] clk_switch,
  input wire fp_trig,
  input wire [1:0] delay_rx,
  output reg [1:0] delay_tx,
  output reg [1:0] frame_phase,
  output reg trig_bp,
  output reg trig_front,
  output reg pair_valid,
  output reg [11:0] pair_strobe,
  output reg [11:0] pair_content,
  output reg [15:0] tx_word,
  output reg [15:0] fiber_tx_a,
  output reg [15:0] fiber_tx_b,
  output reg [15:0] sd_word,
  output reg sd_pulse,
  output reg [1:0] clk_src_sel,
  output reg [7:0] clk_driver_cfg,
  output reg [7:0] bp_clk_sel,
  output reg clk41_en,
  output reg master_mode,
  output reg sync_lost
);
  // =============================================
  // delay meter states
  localparam DLY_IDLE = 3'b001;
  localparam DLY_WAIT = 3'b010;
  localparam DLY_DONE = 3'b100;

  // =============================================
  // pin synchronisers
  reg [15:0] pin_s1; // first stage, read only by pin_s2
  reg [15:0] pin_s2; // safe copy of all async pins
  reg fp_prev; // front-panel edge detect
  reg rx0_prev; // delay return edge detect
  wire [4:0] st_sync = pin_s2[4:0];
  wire [7:0] sw_sync = pin_s2[12:5];
  wire [1:0] dly_sync = pin_s2[14:13];
  wire fp_sync = pin_s2[15];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= 16'h0000;
      pin_s2 <= 16'h0000;
      fp_prev <= 1'b0;
      rx0_prev <= 1'b0;
    end else begin
      pin_s1 <= {fp_trig, delay_rx, clk_switch, fe_status};
      pin_s2 <= pin_s1;
      fp_prev <= fp_sync;
      rx0_prev <= dly_sync[0];
    end
  end

  // =============================================
  // software registers
  reg [31:0] ctrl; // level bits plus self-clearing pulses
  reg [15:0] clkcfg; // [7:0] driver override, [15:8] backplane selects
  reg [18:0] report; // payload, crate_identifier, flag, code
  reg [15:0] fiber_delay; // last measured loop delay
  reg orphan; // content arrived with no strobe waiting
  reg [2:0] dly_state;
  wire apb_xfer = psel & penable & pready; // completing edge
  wire wr_en = apb_xfer & pwrite;
  wire wr_ctrl = wr_en & (paddr == `FTW_REG_CTRL);

  // decode shared by read and write paths
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `FTW_REG_CTRL) | (a == `FTW_REG_CLKCFG) | (a == `FTW_REG_STATUS) |
                  (a == `FTW_REG_DELAY) | (a == `FTW_REG_REPORT) | (a == `FTW_REG_PAIR);
    end
  endfunction

  // one wait state: pready is a flop so the answer always lands one cycle late
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~is_mapped(paddr);
      prdata <= 32'h00000000;
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          `FTW_REG_CTRL: prdata <= ctrl;
          `FTW_REG_CLKCFG: prdata <= {16'h0000, clkcfg};
          `FTW_REG_STATUS: prdata <= {16'h0000, clk_driver_cfg, 3'h0, dly_state == DLY_WAIT, orphan,
                                      master_mode, sync_lost, 1'b0};
          `FTW_REG_DELAY: prdata <= {16'h0000, fiber_delay};
          `FTW_REG_REPORT: prdata <= {13'h0000, report};
          `FTW_REG_PAIR: prdata <= {4'h0, pair_strobe, 4'h0, pair_content};
          default: prdata <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // register writes; pulse bits of ctrl clear themselves the next cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= 32'h00000000;
      clkcfg <= 16'h0000;
      report <= 19'h00000;
    end else begin
      ctrl[`FTW_CTRL_CLR_SYNC] <= 1'b0;
      ctrl[`FTW_CTRL_MEASURE] <= 1'b0;
      ctrl[`FTW_CTRL_REPORT_GO] <= 1'b0;
      ctrl[`FTW_CTRL_CLR_ORPHAN] <= 1'b0;
      if (wr_ctrl) begin
        ctrl <= pwdata;
      end
      if (wr_en & (paddr == `FTW_REG_CLKCFG)) begin
        clkcfg <= pwdata[15:0];
      end
      if (wr_en & (paddr == `FTW_REG_REPORT)) begin
        report <= pwdata[18:0];
      end
    end
  end

  // =============================================
  // clock source and backplane clock control
  wire [7:0] cfg_eff = ctrl[`FTW_CTRL_OVERRIDE] ? clkcfg[7:0] : sw_sync;
  wire src_master = (cfg_eff[1:0] == `FTW_SRC_OSC) | (cfg_eff[1:0] == `FTW_SRC_CABLE);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_driver_cfg <= 8'h00;
      clk_src_sel <= 2'h0;
      master_mode <= 1'b0;
      bp_clk_sel <= 8'h00;
      clk41_en <= 1'b0;
    end else begin
      clk_driver_cfg <= cfg_eff;
      clk_src_sel <= cfg_eff[1:0];
      master_mode <= src_master;
      bp_clk_sel <= clkcfg[15:8];
      clk41_en <= ctrl[`FTW_CTRL_CLK41];
    end
  end

  // =============================================
  // frame phase and local time
  reg [1:0] phase; // 4 ns slot within the 16 ns frame
  reg [13:0] local_time; // counts 4 ns ticks
  wire frame_end = (phase == `FTW_QUAD_LAST);
  wire [1:0] next_phase = phase + 2'h1;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
      frame_phase <= 2'h0;
      local_time <= 14'h0000;
    end else begin
      phase <= next_phase;
      frame_phase <= next_phase;
      local_time <= local_time + 14'h0001;
    end
  end

  // =============================================
  // master-mode generator
  reg gen_strobe_pend; // front-panel trigger not yet sent
  reg [1:0] gen_quad; // slot where the trigger arrived
  reg gen_content_pend; // content owed for a sent strobe
  reg [11:0] gen_count; // trigger number carried in content
  reg [15:0] gen_word; // word of the current frame
  wire fp_edge = fp_sync & ~fp_prev;
  // loopback decodes gen_word one frame after it is built, so it carries the next frame's time
  wire [11:0] gen_time = local_time[13:2] + 12'h001;
  wire [15:0] time_word = {2'h0, `FTW_TYPE_TIME, gen_time};
  wire [15:0] now_time_word = {2'h0, `FTW_TYPE_TIME, local_time[13:2]}; // lines up with gen_word on group a

  // strobe beats content beats time; consume wins over a new front-panel edge for gen_strobe_pend
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gen_strobe_pend <= 1'b0;
      gen_quad <= 2'h0;
      gen_content_pend <= 1'b0;
      gen_count <= 12'h000;
      gen_word <= 16'h0000;
      fiber_tx_a <= 16'h0000;
      fiber_tx_b <= 16'h0000;
      sd_word <= 16'h0000;
      sd_pulse <= 1'b0;
    end else begin
      sd_pulse <= master_mode & ctrl[`FTW_CTRL_SD_PULSE] & fp_edge;
      if (frame_end) begin
        if (gen_strobe_pend) begin
          gen_word <= {2'h0, `FTW_TYPE_STROBE, 2'h0, 8'h01, gen_quad};
          gen_count <= gen_count + 12'h001;
          gen_content_pend <= 1'b1;
        end else if (gen_content_pend) begin
          gen_word <= {2'h0, `FTW_TYPE_CONTENT, gen_count};
          gen_content_pend <= 1'b0;
        end else begin
          gen_word <= time_word;
        end
        fiber_tx_a <= master_mode ? gen_word : 16'h0000;
        fiber_tx_b <= master_mode ? (ctrl[`FTW_CTRL_SAME_GRP] ? gen_word : now_time_word) : 16'h0000;
        sd_word <= (master_mode & ~ctrl[`FTW_CTRL_SD_PULSE]) ? gen_word : 16'h0000;
      end
      if (master_mode & fp_edge & ~gen_strobe_pend) begin
        gen_strobe_pend <= 1'b1;
        gen_quad <= phase;
      end else if (frame_end) begin
        gen_strobe_pend <= 1'b0;
      end
    end
  end

  // =============================================
  // word decode; master mode feeds back its own stream
  wire [15:0] cur_word = master_mode ? gen_word : rx_word;
  wire cur_valid = frame_end & (master_mode | rx_valid);
  wire [1:0] cur_type = cur_word[`FTW_TYPE_HI:`FTW_TYPE_LO];
  wire is_time = cur_valid & (cur_type == `FTW_TYPE_TIME);
  wire is_strobe = cur_valid & (cur_type == `FTW_TYPE_STROBE);
  wire is_content = cur_valid & (cur_type == `FTW_TYPE_CONTENT);
  wire time_bad = is_time & (cur_word[11:0] != local_time[13:2]);

  // sticky sync loss; a mismatch in the clear cycle keeps it set
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_lost <= 1'b0;
    end else if (time_bad) begin
      sync_lost <= 1'b1;
    end else if (ctrl[`FTW_CTRL_CLR_SYNC]) begin
      sync_lost <= 1'b0;
    end
  end

  // =============================================
  // prompt trigger registered out one slot after the chosen slot of the next frame
  reg armed;
  reg [1:0] arm_quad;
  wire fire = armed & (phase == arm_quad);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b0;
      arm_quad <= 2'h0;
      trig_bp <= 1'b0;
      trig_front <= 1'b0;
    end else begin
      trig_bp <= fire;
      trig_front <= fire;
      if (is_strobe) begin
        armed <= 1'b1;
        arm_quad <= cur_word[1:0];
      end else if (fire) begin
        armed <= 1'b0;
      end
    end
  end

  // =============================================
  // strobe/content pairing queue
  reg [QAW:0] q_wr; // extra bit tells full from empty
  reg [QAW:0] q_rd;
  reg pop_d; // memory data arrive one edge after pop
  reg [11:0] content_d;
  wire [11:0] q_rdata;
  wire q_empty = (q_wr == q_rd);
  wire q_full = (q_wr[QAW-1:0] == q_rd[QAW-1:0]) & (q_wr[QAW] != q_rd[QAW]);
  wire q_pop = is_content & ~q_empty;

  ftw_pair_mem #(.WIDTH(12), .AW(QAW)) u_mem (
    .clk(clk),
    .we(is_strobe & ~q_full),
    .waddr(q_wr[QAW-1:0]),
    .wdata(cur_word[11:0]),
    .raddr(q_rd[QAW-1:0]),
    .rdata(q_rdata)
  );

  // first content goes to first unmatched strobe; a full queue drops the strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q_wr <= {(QAW+1){1'b0}};
      q_rd <= {(QAW+1){1'b0}};
      pop_d <= 1'b0;
      content_d <= 12'h000;
      pair_valid <= 1'b0;
      pair_strobe <= 12'h000;
      pair_content <= 12'h000;
      orphan <= 1'b0;
    end else begin
      pop_d <= q_pop;
      pair_valid <= pop_d;
      if (is_strobe & ~q_full) begin
        q_wr <= q_wr + {{QAW{1'b0}}, 1'b1};
      end
      if (q_pop) begin
        q_rd <= q_rd + {{QAW{1'b0}}, 1'b1};
        content_d <= cur_word[11:0];
      end
      if (pop_d) begin
        pair_strobe <= q_rdata;
        pair_content <= content_d;
      end
      if (is_content & q_empty) begin
        orphan <= 1'b1;
      end else if (ctrl[`FTW_CTRL_CLR_ORPHAN]) begin
        orphan <= 1'b0;
      end
    end
  end

  // =============================================
  // return status words, one per frame
  reg report_pend;
  wire [14:0] stat_body = {1'b0, `FTW_TYPE_CTRL, 4'h0, st_sync, 3'h0};
  wire [14:0] rep_body = {1'b0, `FTW_TYPE_STROBE, report[18:16], report[13],
                          (report[18:16] == `FTW_CODE_CRATE) ? {report[12:8], 3'h0} : report[7:0]};

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      report_pend <= 1'b0;
      tx_word <= 16'h0000;
    end else begin
      if (frame_end) begin
        if (report_pend) begin
          tx_word <= {^rep_body, rep_body};
        end else begin
          tx_word <= {^stat_body, stat_body};
        end
      end
      if (ctrl[`FTW_CTRL_REPORT_GO]) begin
        report_pend <= 1'b1;
      end else if (frame_end) begin
        report_pend <= 1'b0;
      end
    end
  end

  // =============================================
  // fiber delay meter and master loopback
  reg [15:0] dly_cnt;
  reg [2:0] pulse_cnt;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dly_state <= DLY_IDLE;
      dly_cnt <= 16'h0000;
      pulse_cnt <= 3'h0;
      fiber_delay <= 16'h0000;
      delay_tx <= 2'h0;
    end else begin
      if (master_mode) begin
        delay_tx <= dly_sync;
      end else begin
        delay_tx <= {1'b0, pulse_cnt != 3'h0};
      end
      if (pulse_cnt != 3'h0) begin
        pulse_cnt <= pulse_cnt - 3'h1;
      end
      case (dly_state)
        DLY_IDLE: begin
          if (ctrl[`FTW_CTRL_MEASURE] & ~master_mode) begin
            dly_state <= DLY_WAIT;
            dly_cnt <= 16'h0000;
            pulse_cnt <= `FTW_DELAY_PULSE;
          end
        end
        DLY_WAIT: begin
          dly_cnt <= dly_cnt + 16'h0001;
          if (dly_sync[0] & ~rx0_prev) begin
            fiber_delay <= dly_cnt;
            dly_state <= DLY_DONE;
          end else if (dly_cnt == `FTW_DELAY_MAX) begin
            fiber_delay <= `FTW_DELAY_MAX;
            dly_state <= DLY_DONE;
          end
        end
        DLY_DONE: begin
          dly_state <= DLY_IDLE;
        end
        default: begin
          dly_state <= DLY_IDLE;
        end
      endcase
    end
  end
endmodule // ftw_top

// file: testbench/ftw_chk.sv
// checker on the ports of ftw_top: apb answer, word link decode, return words
// assumes the bind at the foot of this file and one clock domain clk/nrst
module ftw_chk (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [15:0] rx_word,
  input wire rx_valid,
  input wire [1:0] delay_rx,
  input wire [1:0] delay_tx,
  input wire [1:0] frame_phase,
  input wire trig_bp,
  input wire trig_front,
  input wire pair_valid,
  input wire [15:0] tx_word,
  input wire [15:0] fiber_tx_a,
  input wire master_mode,
  input wire sync_lost
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // =============================================
  // helper logic
  reg [13:0] lt = 14'h0; // mirror of the local time counter
  wire samp = frame_phase == 2'h3 && rx_valid && !master_mode; // word taken from the fiber
  wire cont = samp && rx_word[13:12] == 2'h3; // content word taken
  wire wr_clr = psel && penable && pwrite && pready && paddr == 12'h000 && pwdata[0]; // software clear
  // looped-back content, seen on group a one cycle after it was decoded
  wire gen_cont = master_mode && frame_phase == 2'h0 && fiber_tx_a[13:12] == 2'h3;
  // free running, same start as the design so time words can be judged
  always @(posedge clk or negedge nrst) begin
    if (!nrst) lt <= 14'h0;
    else lt <= lt + 14'h1;
  end
  // =============================================
  // assertions
  property p_apb_wait; psel && penable && !pready |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer missing");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_phase; nrst |=> frame_phase == $past(frame_phase) + 2'h1; endproperty
  a_phase: assert property (p_phase) else $error("frame phase skipped");
  property p_strobe; samp && rx_word[13:12] == 2'h2 |-> ##[2:5] trig_bp; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe gave no trigger");
  property p_prompt; trig_bp |-> trig_front ##1 !trig_bp; endproperty
  a_prompt: assert property (p_prompt) else $error("trigger outputs disagree");
  property p_sync; samp && rx_word[13:12] == 2'h0 && rx_word[11:0] != lt[13:2] |=> sync_lost; endproperty
  a_sync: assert property (p_sync) else $error("time mismatch not flagged");
  property p_sticky; $fell(sync_lost) |-> $past(wr_clr) || $past(wr_clr, 2); endproperty
  a_sticky: assert property (p_sticky) else $error("sync flag dropped alone");
  property p_pair; pair_valid |-> ($past(cont, 2) || $past(gen_cont)) ##1 !pair_valid; endproperty
  a_pair: assert property (p_pair) else $error("pair without content");
  property p_hold; frame_phase != 2'h0 |-> $stable(tx_word); endproperty
  a_hold: assert property (p_hold) else $error("return word moved mid frame");
  property p_parity; tx_word[15] == ^tx_word[14:0] && !tx_word[14]; endproperty
  a_parity: assert property (p_parity) else $error("return parity wrong");
  property p_code; tx_word[13:12] == 2'h2 |-> tx_word[11:9] inside {3'h1, 3'h2, 3'h3}; endproperty
  a_code: assert property (p_code) else $error("bad payload code");
  property p_loop; master_mode && $past(master_mode, 4) |-> delay_tx == $past(delay_rx, 3); endproperty
  a_loop: assert property (p_loop) else $error("delay loop broken");
endmodule // ftw_chk
bind ftw_top ftw_chk ftw_chk_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .rx_word(rx_word), .rx_valid(rx_valid),
  .delay_rx(delay_rx), .delay_tx(delay_tx), .frame_phase(frame_phase), .trig_bp(trig_bp),
  .trig_front(trig_front), .pair_valid(pair_valid), .tx_word(tx_word), .master_mode(master_mode),
  .fiber_tx_a(fiber_tx_a), .sync_lost(sync_lost));

// file: testbench/ftw_up.sv
// upstream sender model: time words, queued words, fiber delay loop
// assumes frame_phase from the design marks the sampling cycle
module ftw_up #(
  parameter LOOP = 20
) (
  input wire clk,
  input wire nrst,
  input wire [1:0] frame_phase,
  input wire [1:0] delay_tx,
  input wire [15:0] word_in,
  input wire word_req,
  input wire slip,
  output reg word_sent = 1'b0,
  output reg [15:0] rx_word = 16'h0,
  output reg rx_valid = 1'b0,
  output reg [1:0] delay_rx = 2'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [13:0] mt = 14'h0; // master time
  reg [LOOP-1:0] line = '0; // fiber loop delay line
  wire [13:0] nt = mt + (slip ? 14'h5 : 14'h1); // time in the sampling cycle, slip runs a frame ahead
  // one word per frame, tb words beat time words
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mt <= 14'h0;
      word_sent <= 1'b0;
      rx_word <= 16'h0;
      rx_valid <= 1'b0;
      line <= '0;
      delay_rx <= 2'h0;
    end else begin
      mt <= mt + 14'h1;
      rx_valid <= 1'b1;
      word_sent <= 1'b0;
      line <= {line[LOOP-2:0], delay_tx[0]};
      delay_rx <= {~line[LOOP-1], line[LOOP-1]};
      // tb orders strobe, content and control itself
      if (frame_phase == 2'h2 && word_req) begin
        rx_word <= word_in;
        word_sent <= 1'b1;
      end else begin
        rx_word <= {4'h0, nt[13:2]};
      end
    end
  end
endmodule // ftw_up

// file: testbench/ftw_top_tb.sv
// self-checking bench for ftw_top with the upstream model
// assumes design files and ftw_defs.vh compiled before it
module ftw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fp_trig = 1'b0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, rd, rep [0:2];
  reg [4:0] fe_status = 5'h15; // busy, ack2, roc ack set
  reg [7:0] clk_switch = 8'h02; // central fiber: standard mode
  reg [15:0] word_in = 16'h0;
  reg word_req = 1'b0, slip = 1'b0, err, got, fib;
  reg [8:0] rexp [0:2];
  wire [31:0] prdata;
  wire [15:0] rx_word, tx_word, fa, fb;
  wire [11:0] ps, pc;
  wire [7:0] cdc, bps;
  wire [1:0] drx, dtx, fph, css;
  wire pready, pslverr, rx_valid, tbp, tfr, pv, c41, mm, sl, sent;
  integer n_errors = 0, checks = 0, cyc = 0, i, k;
  always #2 clk = ~clk;
  ftw_top ftw_top_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_word(rx_word), .rx_valid(rx_valid),
    .fe_status(fe_status), .clk_switch(clk_switch), .fp_trig(fp_trig), .delay_rx(drx), .delay_tx(dtx),
    .frame_phase(fph), .trig_bp(tbp), .trig_front(tfr), .pair_valid(pv), .pair_strobe(ps), .pair_content(pc),
    .tx_word(tx_word), .fiber_tx_a(fa), .fiber_tx_b(fb), .sd_word(), .sd_pulse(), .clk_src_sel(css),
    .clk_driver_cfg(cdc), .bp_clk_sel(bps), .clk41_en(c41), .master_mode(mm), .sync_lost(sl));
  ftw_up ftw_up_inst (.clk(clk), .nrst(nrst), .frame_phase(fph), .delay_tx(dtx), .word_in(word_in),
    .word_req(word_req), .slip(slip), .word_sent(sent), .rx_word(rx_word), .rx_valid(rx_valid), .delay_rx(drx));
  // =============================================
  // tasks
  task report_and_stop;
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    checks = checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  // setup, access, wait for pready, take data at that edge
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k = k + 1; end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // hand one word to the upstream model, return at its sampling edge
  task send(input [15:0] w);
    @(posedge clk);
    word_in <= w; word_req <= 1'b1;
    k = 0;
    do begin @(posedge clk); k = k + 1; end while (sent !== 1'b1 && k < 40);
    word_req <= 1'b0;
  endtask
  // bounded wait on a design output
  task wait_hi(input reg which);
    k = 0;
    do begin @(posedge clk); k = k + 1; end while ((which ? pv : tbp) !== 1'b1 && k < 10);
  endtask
  // a hang counts as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  // =============================================
  // main sequence
  initial begin
    rep[0] = 32'h00011600; rexp[0] = 9'h056; // crate_identifier
    rep[1] = 32'h000320a5; rexp[1] = 9'h0f4; // buffer level
    rep[2] = 32'h0002203c; rexp[2] = 9'h0a7; // active trigger source
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (60) @(posedge clk);
    chk(sl, 0, "sync_ok");
    chk(mm, 0, "std_mode");
    chk({css, cdc, fa}, {2'h2, 8'h02, 16'h0}, "clk_dflt");
    chk(tx_word, 16'h10a8, "status");
    fe_status <= 5'h03;
    repeat (12) @(posedge clk);
    chk(tx_word, 16'h9018, "parity");
    apb(0, 12'hffc, 0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped");
    apb(1, 12'h004, 32'h0000e45a);
    apb(1, 12'h000, 32'h00000044);
    apb(0, 12'h004, 0);
    chk({rd, cdc, bps, c41}, {32'he45a, 8'h5a, 8'he4, 1'b1}, "clk_ovr");
    // every quadrant, strobes with tag bits 15:14 set, contents with bit 14 only, each strobe then its content
    for (i = 0; i < 4; i = i + 1) begin
      send(16'hec00 | i[15:0]);
      wait_hi(0);
      chk({tbp, tfr, fph}, {2'h3, i[1:0] + 2'h1}, "quadrant");
      send(16'h7d00 | i[15:0]);
      wait_hi(1);
      chk({pv, ps, pc}, {1'b1, 12'hc00 | i[11:0], 12'hd00 | i[11:0]}, "pair");
    end
    // two strobes ahead of two contents: oldest first
    send(16'h2a50);
    send(16'h2b61);
    send(16'h3123);
    wait_hi(1);
    chk({ps, pc}, 24'ha50123, "pair_1");
    send(16'h3456);
    wait_hi(1);
    chk({ps, pc}, 24'hb61456, "pair_2");
    apb(0, 12'h014, 0);
    chk(rd, 32'h0b610456, "pair_reg");
    send(16'h1234);
    send(16'h3777);
    apb(0, 12'h008, 0);
    chk(rd[3], 1, "orphan");
    apb(1, 12'h000, 32'h00000080);
    apb(0, 12'h008, 0);
    chk({rd[4:1], rd[15:8]}, {4'h0, 8'h02}, "orph_clr");
    slip <= 1'b1;
    repeat (12) @(posedge clk);
    slip <= 1'b0;
    repeat (20) @(posedge clk);
    apb(0, 12'h008, 0);
    chk({sl, rd[1]}, 2'h3, "sync_lost");
    apb(1, 12'h000, 32'h00000001);
    repeat (3) @(posedge clk);
    chk(sl, 0, "sync_clr");
    for (i = 0; i < 3; i = i + 1) begin
      apb(1, 12'h010, rep[i]);
      apb(1, 12'h000, 32'h00000020);
      k = 0;
      do begin @(posedge clk); k = k + 1; end while (tx_word[13:12] !== 2'h2 && k < 20);
      chk(tx_word[14:3], {3'h2, rexp[i]}, "report");
    end
    apb(1, 12'h000, 32'h00000002);
    i = 0;
    do begin apb(0, 12'h008, 0); i = i + 1; end while (rd[4] !== 1'b0 && i < 30);
    apb(0, 12'h00c, 0);
    chk(rd >= 32'd21 && rd <= 32'd27, 1, "delay");
    // oscillator source: master mode, front panel trigger
    clk_switch <= 8'h00;
    apb(1, 12'h000, 32'h00000008);
    chk(mm, 1, "master");
    fp_trig <= 1'b1;
    got = 1'b0;
    fib = 1'b0;
    repeat (40) begin
      @(posedge clk);
      got = got | tbp;
      fib = fib | (fa[13:12] === 2'h2);
    end
    chk({got, fib, fa}, {2'h3, fb}, "master_trig");
    chk(sl, 0, "master_sync");
    report_and_stop;
  end
endmodule // ftw_top_tb
